// >>> rtl/scw_pkg.sv
/*
 * Constants and carrier types for the sleep-clock and wake-timing block.
 * Assumes a 100 MHz core clock and an 8-bit register port with 10-bit addresses.
 */
`default_nettype none
package scw_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [9:0] ADDR_CLK_SRC  = 10'h208;
	localparam logic [9:0] ADDR_CAL_LO   = 10'h209;
	localparam logic [9:0] ADDR_CAL_MID  = 10'h20a;
	localparam logic [9:0] ADDR_CAL_HI   = 10'h20b;
	localparam logic [9:0] ADDR_IRQ_CLK  = 10'h211;
	localparam logic [9:0] ADDR_DIV      = 10'h220;
	localparam logic [9:0] ADDR_WAKE_LO  = 10'h222;
	localparam logic [9:0] ADDR_WAKE_HI  = 10'h223;
	localparam logic [9:0] ADDR_REM_LO   = 10'h224;
	localparam logic [9:0] ADDR_REM_HI   = 10'h225;
	localparam logic [9:0] ADDR_MAIN0    = 10'h226;
	localparam logic [9:0] ADDR_MAIN1    = 10'h227;
	localparam logic [9:0] ADDR_MAIN2    = 10'h228;
	localparam logic [9:0] ADDR_MAIN3    = 10'h229;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_OSC   = 4;
	localparam int BIT_SRC   = 0;
	localparam int BIT_RDY   = 7;
	localparam int BIT_START = 4;
	localparam int BIT_POL   = 1;
	localparam int BIT_OFF   = 0;
	localparam int BIT_WDT   = 7;
	localparam int BIT_CLKEN = 5;
	localparam int BIT_SLEEP = 7;
	// ------------------------------------------------------------
	// widths, reset values, timing
	// ------------------------------------------------------------
	localparam int          DIV_W        = 5;
	localparam int          WAKE_W       = 11;
	localparam int          CAL_W        = 20;
	localparam logic [10:0] WAKE_RST     = 11'h00a;
	localparam logic [4:0]  CAL_CYCLES   = 5'h10;
	localparam logic [3:0]  BO_UNSLOTTED = 4'hf;
	localparam int          CORE_PERIOD_NS = 10;
	localparam int          CAL_UNIT_NS    = 50;
	localparam logic [2:0]  CAL_TICK_CYC   = 3'(CAL_UNIT_NS / CORE_PERIOD_NS);

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [9:0]  addr;
		logic [7:0]  wdata;
	} scw_req_type;

	typedef struct packed {
		logic        osc_tuning_ctrl;
		logic        clock_output_source_sel;
		logic        interrupt_edge_sel;
		logic        sleep_clock_off;
		logic        two_wire_watchdog_on;
		logic        clock_output_on;
		logic [4:0]  sleep_divider_exp;
		logic [15:0] remain_counter;
		logic [25:0] main_counter;
	} scw_cfg_type;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_ARM  = 3'b010,
		CAL_RUN  = 3'b100
	} scw_cal_type;
endpackage : scw_pkg
`default_nettype wire

// >>> rtl/scw_sleep_clock_wake_timers.sv
/*
 * Sleep-clock calibration, divider, wake down-counter, clock-output select and
 * the configuration registers behind the parallel register port.
 * Assumes sleep_clk_in, analog_clk20 and pm_clk20 are levels synchronous to core_clk.
 */
`default_nettype none
// Behaviour
// - source select 0 routes analogue 20 MHz clock out, 1 routes power-management clock.
// - calibration counts 50 ns ticks over 16 sleep-clock cycles.
// - 20-bit result reads as low byte, mid byte and status low nibble.
// - writing 1 to the start bit launches calibration; bit reads zero.
// - ready flag is 0 without result, 1 once 16 cycles are timed.
// - edge-select bit picks falling (0) or rising (1) interrupt edge.
// - watchdog enable bit switches two-wire watchdog on when 1.
// - clock-output enable drives output pin when 1, holds it low when 0.
// - divider field n divides sleep clock by 2^n; resets to zero.
// - 11-bit wake down-counter on sleep clock; resets to 0x00a.
// - 16-bit remain counter in two read/write bytes, reset zero.
// - main counter bits 23..0 in three read/write bytes, reset zero.
// - main counter bits 25..24 sit in the following register.
// - sleep trigger starts sleep in unslotted mode, clears on wake.
module scw_sleep_clock_wake_timers (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	input  wire scw_pkg::scw_req_type reg_req,
	output logic [7:0]                reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic                 sleep_clk_in,
	input  wire logic                 analog_clk20,
	input  wire logic                 pm_clk20,
	input  wire logic [3:0]           beacon_order,
	input  wire logic                 slotted_mode,
	output scw_pkg::scw_cfg_type      cfg_o,
	output logic                      clk_out_pin,
	output logic                      sleep_tick_o,
	output logic                      sleep_active_o,
	output logic                      wake_pulse_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	scw_pkg::scw_cfg_type cfg_q, cfg_d;
	scw_pkg::scw_cal_type cal_st_q, cal_st_d;
	logic [19:0] cal_cnt_q, cal_cnt_d, cal_res_q, cal_res_d;
	logic [4:0]  edge_cnt_q, edge_cnt_d;
	logic        ready_q, ready_d;
	logic [2:0]  tick_cnt_q, tick_cnt_d;
	logic        tick_q, tick_d;
	logic        slp_prev_q;
	logic [31:0] div_cnt_q, div_cnt_d;
	logic        stick_q, stick_d;
	logic [10:0] wake_time_q, wake_time_d, wake_cnt_q, wake_cnt_d;
	logic        sleep_q, sleep_d, wake_q, wake_d;
	logic        clko_q, clko_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        rvalid_q;
	logic        slp_edge, div_tick, cal_go, cal_fin, slp_go, wake_now;

	function automatic logic hit(input scw_pkg::scw_req_type r, input logic [9:0] a);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	function automatic logic [31:0] div_mask(input logic [4:0] n);
		div_mask = (32'h1 << n) - 32'h1;
	endfunction : div_mask

	// ------------------------------------------------------------
	// sleep clock edge, divider and 20 MHz tick
	// ------------------------------------------------------------
	// stopped sleep clock yields no edges
	assign slp_edge = sleep_clk_in && !slp_prev_q && !cfg_q.sleep_clock_off;
	assign div_tick = slp_edge && ((div_cnt_q & div_mask(cfg_q.sleep_divider_exp)) ==
		div_mask(cfg_q.sleep_divider_exp));

	localparam logic [2:0] CAL_TICK_CYC_M1 = scw_pkg::CAL_TICK_CYC - 3'h1;

	// next values of tick generator and divider
	always_comb
	begin
		tick_cnt_d = (tick_cnt_q == CAL_TICK_CYC_M1) ? 3'h0 : tick_cnt_q + 3'h1;
		tick_d     = (tick_cnt_q == CAL_TICK_CYC_M1);
		div_cnt_d  = slp_edge ? div_cnt_q + 32'h1 : div_cnt_q;
		stick_d    = div_tick;
	end

	// ------------------------------------------------------------
	// calibration counter
	// ------------------------------------------------------------
	assign cal_go  = hit(reg_req, scw_pkg::ADDR_CAL_HI) && reg_req.wdata[scw_pkg::BIT_START];
	assign cal_fin = (cal_st_q == scw_pkg::CAL_RUN) && slp_edge &&
		(edge_cnt_q == scw_pkg::CAL_CYCLES - 5'h1);

	// arm on start, time 16 sleep edges in 50 ns ticks, finishing beats a restart
	always_comb
	begin
		cal_st_d   = cal_st_q;
		cal_cnt_d  = cal_cnt_q;
		edge_cnt_d = edge_cnt_q;
		cal_res_d  = cal_res_q;
		ready_d    = ready_q;
		if (cal_fin)
		begin
			cal_st_d  = scw_pkg::CAL_IDLE;
			cal_res_d = cal_cnt_q;
			ready_d   = 1'b1;
		end
		else if (cal_go)
		begin
			cal_st_d = scw_pkg::CAL_ARM;
			ready_d  = 1'b0;
		end
		else
		begin
			case (cal_st_q)
				scw_pkg::CAL_IDLE: cal_st_d = scw_pkg::CAL_IDLE;
				scw_pkg::CAL_ARM:
				begin
					if (slp_edge)
					begin
						cal_st_d   = scw_pkg::CAL_RUN;
						cal_cnt_d  = 20'h0;
						edge_cnt_d = 5'h0;
					end
				end
				scw_pkg::CAL_RUN:
				begin
					if (tick_q && (cal_cnt_q != 20'hfffff))
						cal_cnt_d = cal_cnt_q + 20'h1;
					if (slp_edge)
						edge_cnt_d = edge_cnt_q + 5'h1;
				end
				default: cal_st_d = scw_pkg::CAL_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// wake down-counter and sleep trigger
	// ------------------------------------------------------------
	assign slp_go = hit(reg_req, scw_pkg::ADDR_MAIN3) && reg_req.wdata[scw_pkg::BIT_SLEEP] && !sleep_q &&
		(beacon_order == scw_pkg::BO_UNSLOTTED) && !slotted_mode;
	assign wake_now = sleep_q && div_tick && (wake_cnt_q <= 11'h001);

	// load on sleep entry, count divided sleep ticks, wake at the bottom
	always_comb
	begin
		sleep_d    = sleep_q;
		wake_d     = 1'b0;
		wake_cnt_d = wake_cnt_q;
		if (slp_go)
		begin
			sleep_d    = 1'b1;
			wake_cnt_d = wake_time_q;
		end
		else if (wake_now)
		begin
			sleep_d = 1'b0;
			wake_d  = 1'b1;
		end
		else if (sleep_q && div_tick)
			wake_cnt_d = wake_cnt_q - 11'h001;
	end

	// ------------------------------------------------------------
	// register writes and clock output
	// ------------------------------------------------------------
	always_comb
	begin
		cfg_d       = cfg_q;
		wake_time_d = wake_time_q;
		if (hit(reg_req, scw_pkg::ADDR_CLK_SRC))
		begin
			cfg_d.osc_tuning_ctrl         = reg_req.wdata[scw_pkg::BIT_OSC];
			cfg_d.clock_output_source_sel = reg_req.wdata[scw_pkg::BIT_SRC];
		end
		if (hit(reg_req, scw_pkg::ADDR_IRQ_CLK))
		begin
			cfg_d.interrupt_edge_sel = reg_req.wdata[scw_pkg::BIT_POL];
			cfg_d.sleep_clock_off    = reg_req.wdata[scw_pkg::BIT_OFF];
		end
		if (hit(reg_req, scw_pkg::ADDR_DIV))
		begin
			cfg_d.two_wire_watchdog_on = reg_req.wdata[scw_pkg::BIT_WDT];
			cfg_d.clock_output_on      = reg_req.wdata[scw_pkg::BIT_CLKEN];
			cfg_d.sleep_divider_exp    = reg_req.wdata[4:0];
		end
		if (hit(reg_req, scw_pkg::ADDR_WAKE_LO))
			wake_time_d[7:0] = reg_req.wdata;
		if (hit(reg_req, scw_pkg::ADDR_WAKE_HI))
			wake_time_d[10:8] = reg_req.wdata[2:0];
		if (hit(reg_req, scw_pkg::ADDR_REM_LO))
			cfg_d.remain_counter[7:0] = reg_req.wdata;
		if (hit(reg_req, scw_pkg::ADDR_REM_HI))
			cfg_d.remain_counter[15:8] = reg_req.wdata;
		if (hit(reg_req, scw_pkg::ADDR_MAIN0))
			cfg_d.main_counter[7:0] = reg_req.wdata;
		if (hit(reg_req, scw_pkg::ADDR_MAIN1))
			cfg_d.main_counter[15:8] = reg_req.wdata;
		if (hit(reg_req, scw_pkg::ADDR_MAIN2))
			cfg_d.main_counter[23:16] = reg_req.wdata;
		if (hit(reg_req, scw_pkg::ADDR_MAIN3))
			cfg_d.main_counter[25:24] = reg_req.wdata[1:0];
		// gated, selected 20 MHz clock out
		clko_d = cfg_q.clock_output_on &&
			(cfg_q.clock_output_source_sel ? pm_clk20 : analog_clk20);
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	always_comb
	begin
		rdata_d = 8'h00;
		case (reg_req.addr)
			scw_pkg::ADDR_CLK_SRC: rdata_d = {3'h0, cfg_q.osc_tuning_ctrl, 3'h0, cfg_q.clock_output_source_sel};
			scw_pkg::ADDR_CAL_LO:  rdata_d = cal_res_q[7:0];
			scw_pkg::ADDR_CAL_MID: rdata_d = cal_res_q[15:8];
			scw_pkg::ADDR_CAL_HI:  rdata_d = {ready_q, 3'h0, cal_res_q[19:16]};
			scw_pkg::ADDR_IRQ_CLK: rdata_d = {6'h00, cfg_q.interrupt_edge_sel, cfg_q.sleep_clock_off};
			scw_pkg::ADDR_DIV:     rdata_d = {cfg_q.two_wire_watchdog_on, 1'b0, cfg_q.clock_output_on,
				cfg_q.sleep_divider_exp};
			scw_pkg::ADDR_WAKE_LO: rdata_d = wake_time_q[7:0];
			scw_pkg::ADDR_WAKE_HI: rdata_d = {5'h00, wake_time_q[10:8]};
			scw_pkg::ADDR_REM_LO:  rdata_d = cfg_q.remain_counter[7:0];
			scw_pkg::ADDR_REM_HI:  rdata_d = cfg_q.remain_counter[15:8];
			scw_pkg::ADDR_MAIN0:   rdata_d = cfg_q.main_counter[7:0];
			scw_pkg::ADDR_MAIN1:   rdata_d = cfg_q.main_counter[15:8];
			scw_pkg::ADDR_MAIN2:   rdata_d = cfg_q.main_counter[23:16];
			scw_pkg::ADDR_MAIN3:   rdata_d = {sleep_q, 5'h00, cfg_q.main_counter[25:24]};
			default:               rdata_d = 8'h00;
		endcase
		if (!reg_req.rd)
			rdata_d = 8'h00;
	end

	// ------------------------------------------------------------
	// registering, frozen while clk_en is low
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cfg_q       <= '0;
			cal_st_q    <= scw_pkg::CAL_IDLE;
			cal_cnt_q   <= 20'h0;
			cal_res_q   <= 20'h0;
			edge_cnt_q  <= 5'h0;
			ready_q     <= 1'b0;
			tick_cnt_q  <= 3'h0;
			tick_q      <= 1'b0;
			slp_prev_q  <= 1'b0;
			div_cnt_q   <= 32'h0;
			stick_q     <= 1'b0;
			wake_time_q <= scw_pkg::WAKE_RST;
			wake_cnt_q  <= scw_pkg::WAKE_RST;
			sleep_q     <= 1'b0;
			wake_q      <= 1'b0;
			clko_q      <= 1'b0;
			rdata_q     <= 8'h00;
			rvalid_q    <= 1'b0;
		end
		else if (clk_en)
		begin
			cfg_q       <= cfg_d;
			cal_st_q    <= cal_st_d;
			cal_cnt_q   <= cal_cnt_d;
			cal_res_q   <= cal_res_d;
			edge_cnt_q  <= edge_cnt_d;
			ready_q     <= ready_d;
			tick_cnt_q  <= tick_cnt_d;
			tick_q      <= tick_d;
			slp_prev_q  <= sleep_clk_in;
			div_cnt_q   <= div_cnt_d;
			stick_q     <= stick_d;
			wake_time_q <= wake_time_d;
			wake_cnt_q  <= wake_cnt_d;
			sleep_q     <= sleep_d;
			wake_q      <= wake_d;
			clko_q      <= clko_d;
			rdata_q     <= rdata_d;
			rvalid_q    <= reg_req.rd;
		end
	end

	// outputs straight from flip-flops
	assign cfg_o          = cfg_q;
	assign clk_out_pin    = clko_q;
	assign sleep_tick_o   = stick_q;
	assign sleep_active_o = sleep_q;
	assign wake_pulse_o   = wake_q;
	assign reg_rdata      = rdata_q;
	assign reg_rvalid     = rvalid_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !clk_en);

	sequence s_tick_gap;
		!tick_q [*4] ##1 tick_q;
	endsequence

	a_tick_period:    assert property (tick_q |=> s_tick_gap) else $error("tick period wrong");
	a_sixteen_edges:  assert property (cal_fin |=> ready_q && edge_cnt_q == 5'h0f)
		else $error("ready not set after 16 edges");
	a_start_clears:   assert property (cal_go && !cal_fin |=> !ready_q && cal_st_q == scw_pkg::CAL_ARM)
		else $error("start did not clear ready");
	a_result_frozen:  assert property (ready_q && !cal_go |=> $stable(cal_res_q))
		else $error("result changed while ready");
	a_start_reads_0:  assert property (reg_req.rd && reg_req.addr == scw_pkg::ADDR_CAL_HI |=>
		reg_rvalid && !reg_rdata[scw_pkg::BIT_START]) else $error("start bit read as one");
	a_clk_out_off:    assert property (!cfg_q.clock_output_on |=> !clk_out_pin)
		else $error("clock output active while off");
	a_clk_src_pm:     assert property (cfg_q.clock_output_on && cfg_q.clock_output_source_sel |=>
		clk_out_pin == $past(pm_clk20)) else $error("wrong clock source");
	a_sleep_off_tick: assert property (cfg_q.sleep_clock_off |=> !sleep_tick_o)
		else $error("sleep tick while clock stopped");
	a_div_zero:       assert property (cfg_q.sleep_divider_exp == 5'h00 && slp_edge |=> sleep_tick_o)
		else $error("undivided tick missing");
	a_wake_count:     assert property (sleep_q && div_tick && wake_cnt_q > 11'h001 |=>
		sleep_q && wake_cnt_q == $past(wake_cnt_q) - 11'h001) else $error("wake counter step wrong");
	a_wake_clears:    assert property (wake_now |=> !sleep_q && wake_pulse_o ##1 !wake_pulse_o)
		else $error("sleep trigger not cleared at wake");
endmodule : scw_sleep_clock_wake_timers
`default_nettype wire

// >>> test/scw_host_model.sv
/*
 * Host model: issues single writes and reads on the parallel register port.
 * Assumes requests launch on a falling edge and the answer stands one cycle.
 */
`default_nettype none
module scw_host_model (
	input  wire logic                 core_clk,
	output var scw_pkg::scw_req_type  reg_req,
	input  wire logic [7:0]           reg_rdata,
	input  wire logic                 reg_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	// -----------------------------------------------------------
	// request tasks
	// -----------------------------------------------------------
	initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 10'h3ff, wdata: 8'hff};
	// released bus shows the inverse of the last request, never a stale copy
	task automatic idle();
		reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
	endtask : idle
	// one write strobe for one cycle
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge core_clk);
		idle();
	endtask : wr
	// one read strobe; answer taken in the cycle it stands
	task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
		@(negedge core_clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge core_clk);
		idle();
		v = reg_rvalid;
		d = reg_rdata;
	endtask : rd
endmodule : scw_host_model
`default_nettype wire

// >>> test/test_sleep_clock_wake_timers.sv
/*
 * Self-checking bench for the sleep-clock and wake-timing block.
 * Assumes the host model owns the register port; the bench drives the other inputs.
 */
`default_nettype none
module test_sleep_clock_wake_timers;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 core_clk, rst_n, clk_en, analog_clk20, pm_clk20, slotted_mode;
	logic                 sleep_clk_in = 1'b0;
	logic [3:0]           beacon_order;
	scw_pkg::scw_req_type reg_req;
	scw_pkg::scw_cfg_type cfg_o;
	logic [7:0]           reg_rdata, rd_d;
	logic                 reg_rvalid, clk_out_pin, sleep_tick_o, sleep_active_o, wake_pulse_o, rd_v;
	int                   error_cnt = 0, checks = 0, cyc = 0, sl_cnt = 0;
	localparam int SLEEP_HALF = 10; // 20-cycle sleep period: 16 periods are 64 units of 50 ns
	localparam int LIMIT = 20000;
	localparam logic [9:0] ADDR_T [15] = '{10'h208, 10'h209, 10'h20a, 10'h20b, 10'h210, 10'h211, 10'h220,
		10'h222, 10'h223, 10'h224, 10'h225, 10'h226, 10'h227, 10'h228, 10'h229};
	localparam logic [7:0] RST_T [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MASK_T [15] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hbf, 8'hff,
		8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03};

	scw_sleep_clock_wake_timers scw_sleep_clock_wake_timers_i (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.sleep_clk_in(sleep_clk_in), .analog_clk20(analog_clk20), .pm_clk20(pm_clk20),
		.beacon_order(beacon_order), .slotted_mode(slotted_mode), .cfg_o(cfg_o), .clk_out_pin(clk_out_pin),
		.sleep_tick_o(sleep_tick_o), .sleep_active_o(sleep_active_o), .wake_pulse_o(wake_pulse_o));
	scw_host_model scw_host_model_i (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	// -----------------------------------------------------------
	// clock, sleep clock and cycle ceiling
	// -----------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// sleep clock runs free as a level; a hang ends the run
	always @(negedge core_clk)
	begin
		cyc <= cyc + 1;
		sl_cnt <= (sl_cnt == SLEEP_HALF - 1) ? 0 : sl_cnt + 1;
		if (sl_cnt == SLEEP_HALF - 1)
			sleep_clk_in <= ~sleep_clk_in;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			$display("BAD cycle ceiling exp %0d got %0d", LIMIT, cyc);
			test_done();
		end
	end

	// -----------------------------------------------------------
	// compare and helper tasks
	// -----------------------------------------------------------
	task automatic cmp_val(input string what, input logic [25:0] exp, input logic [25:0] got);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : cmp_val
	// read one register and judge both the answer strobe and the data
	task automatic cmp_reg(input logic [9:0] a, input logic [7:0] exp);
		scw_host_model_i.rd(a, rd_d, rd_v);
		cmp_val($sformatf("rvalid at %h", a), 26'(1'b1), 26'(rd_v));
		cmp_val($sformatf("reg %h", a), 26'(exp), 26'(rd_d));
	endtask : cmp_reg
	// poll the status register until the result is ready
	task automatic wait_ready();
		int n;
		n = 0;
		rd_d = 8'h00;
		while (rd_d[7] !== 1'b1 && n < 300)
		begin
			scw_host_model_i.rd(10'h20b, rd_d, rd_v);
			n++;
		end
		cmp_val("cal ready", 26'(1'b1), 26'(rd_d[7]));
	endtask : wait_ready

	// -----------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------
	task automatic test_reset();
		for (int i = 0; i < 15; i++)
			cmp_reg(ADDR_T[i], RST_T[i]);
		$display("test reset done");
	endtask : test_reset
	// two patterns through every place, read-only and unmapped ones included
	task automatic test_regs();
		logic [7:0] p;
		for (int k = 0; k < 2; k++)
		begin
			p = (k == 0) ? 8'hff : 8'h6a;
			for (int i = 0; i < 15; i++)
				scw_host_model_i.wr(ADDR_T[i], (ADDR_T[i] == 10'h20b) ? (p & 8'hef) : p);
			for (int i = 0; i < 15; i++)
				cmp_reg(ADDR_T[i], (p & MASK_T[i]) | (RST_T[i] & ~MASK_T[i]));
			cmp_val("cfg flags", 26'({p[4], p[0], p[1], p[0], p[7], p[5], p[4:0]}), 26'(cfg_o[52:42]));
			cmp_val("cfg remain", 26'({p, p}), 26'(cfg_o.remain_counter));
			cmp_val("cfg main", {p[1:0], p, p, p}, cfg_o.main_counter);
		end
		$display("test regs done");
	endtask : test_regs
	// output pin follows the selected source only while enabled
	task automatic test_clkout();
		analog_clk20 = 1'b1;
		scw_host_model_i.wr(10'h220, 8'h20);
		scw_host_model_i.wr(10'h208, 8'h10);
		repeat (2) @(negedge core_clk);
		cmp_val("clk_out_pin analog", 26'(1'b1), 26'(clk_out_pin));
		scw_host_model_i.wr(10'h208, 8'h11);
		repeat (2) @(negedge core_clk);
		cmp_val("clk_out_pin pm low", 26'(1'b0), 26'(clk_out_pin));
		pm_clk20 = 1'b1;
		analog_clk20 = 1'b0;
		repeat (2) @(negedge core_clk);
		cmp_val("clk_out_pin pm high", 26'(1'b1), 26'(clk_out_pin));
		// clock enable low holds the pin; five cycles keep the 50 ns tick phase
		clk_en = 1'b0;
		pm_clk20 = 1'b0;
		repeat (5) @(negedge core_clk);
		cmp_val("clk_out_pin frozen", 26'(1'b1), 26'(clk_out_pin));
		clk_en = 1'b1;
		repeat (2) @(negedge core_clk);
		cmp_val("clk_out_pin pm low again", 26'(1'b0), 26'(clk_out_pin));
		pm_clk20 = 1'b1;
		scw_host_model_i.wr(10'h220, 8'h00);
		repeat (2) @(negedge core_clk);
		cmp_val("clk_out_pin off", 26'(1'b0), 26'(clk_out_pin));
		$display("test clkout done");
	endtask : test_clkout
	// measure, freeze, restart under a stopped sleep clock, resume
	task automatic test_cal();
		scw_host_model_i.wr(10'h211, 8'h00);
		scw_host_model_i.wr(10'h20b, 8'h10);
		cmp_reg(10'h20b, 8'h00);
		wait_ready();
		cmp_reg(10'h209, 8'h40);
		cmp_reg(10'h20a, 8'h00);
		cmp_reg(10'h20b, 8'h80);
		repeat (400) @(negedge core_clk);
		cmp_reg(10'h209, 8'h40);
		scw_host_model_i.wr(10'h211, 8'h01);
		scw_host_model_i.wr(10'h20b, 8'h10);
		repeat (400) @(negedge core_clk);
		cmp_reg(10'h20b, 8'h00);
		scw_host_model_i.wr(10'h211, 8'h00);
		wait_ready();
		cmp_reg(10'h209, 8'h40);
		$display("test cal done");
	endtask : test_cal
	// sleep refused when slotted, then three divided ticks to wake
	task automatic test_wake();
		int n, t, last, gap;
		n = 0;
		t = 0;
		last = 0;
		gap = 0;
		scw_host_model_i.wr(10'h220, 8'h01);
		scw_host_model_i.wr(10'h222, 8'h03);
		scw_host_model_i.wr(10'h223, 8'h00);
		beacon_order = 4'hf;
		slotted_mode = 1'b1;
		scw_host_model_i.wr(10'h229, 8'h80);
		cmp_val("sleep refused", 26'(1'b0), 26'(sleep_active_o));
		slotted_mode = 1'b0;
		scw_host_model_i.wr(10'h229, 8'h80);
		cmp_val("sleep_active_o", 26'(1'b1), 26'(sleep_active_o));
		while (wake_pulse_o !== 1'b1 && t < 2000)
		begin
			@(negedge core_clk);
			t++;
			if (sleep_tick_o === 1'b1)
			begin
				n++;
				gap = t - last;
				last = t;
			end
		end
		cmp_val("ticks to wake", 26'(3), 26'(n));
		cmp_val("tick spacing", 26'(2 * 2 * SLEEP_HALF), 26'(gap));
		@(negedge core_clk);
		cmp_val("sleep_active_o after wake", 26'(1'b0), 26'(sleep_active_o));
		cmp_reg(10'h229, 8'h00);
		$display("test wake done");
	endtask : test_wake

	task automatic test_done();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// reset for two cycles, then the scenarios in turn
	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		analog_clk20 = 1'b0;
		pm_clk20 = 1'b0;
		beacon_order = 4'h0;
		slotted_mode = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		test_reset();
		test_regs();
		test_clkout();
		test_cal();
		test_wake();
		test_done();
	end
endmodule : test_sleep_clock_wake_timers
`default_nettype wire
